//--- src/csb_pkg.sv
package csb_pkg;

    // Bit positions inside the core status byte.
    localparam int CSB_BIT_IND  = 7;
    localparam int CSB_BIT_HI   = 6;
    localparam int CSB_BIT_LO   = 5;
    localparam int CSB_BIT_WEXP = 4;
    localparam int CSB_BIT_SLP  = 3;
    localparam int CSB_BIT_ZERO = 2;
    localparam int CSB_BIT_NIB  = 1;
    localparam int CSB_BIT_CRY  = 0;

    // Time-out and power-down read one after reset; the rest read zero.
    localparam logic [7:0] CSB_STATUS_RST = 8'h18;

    // Bits that an instruction or a bus write may change.
    localparam logic [7:0] CSB_WR_MASK  = 8'he7;
    localparam logic [7:0] CSB_ALU_MASK = 8'h07;

    // Width of the in-bank offset; a bank spans 128 bytes.
    localparam int CSB_OFS_W      = 7;
    localparam int CSB_BANK_BYTES = 128;

    // Avalon word indices of the registers.
    localparam logic [1:0] CSB_ADR_STATUS = 2'h0;
    localparam logic [1:0] CSB_ADR_SHADOW = 2'h1;
    localparam logic [1:0] CSB_ADR_ADDR   = 2'h2;

    typedef enum logic [2:0] {
        CSB_OP_NONE,
        CSB_OP_ADD,
        CSB_OP_SUB,
        CSB_OP_LOGIC,
        CSB_OP_ROTL,
        CSB_OP_ROTR
    } csb_alu_op_t;

endpackage

//--- src/csb_flag_unit.sv
`timescale 1ns/10ps
module csb_flag_unit
    import csb_pkg::*;
(
    input  csb_alu_op_t       op,
    input  wire logic [7:0]   opa,
    input  wire logic [7:0]   opb,
    input  wire logic         carry_in,
    output logic      [7:0]   result,
    output logic      [2:0]   flags,
    output logic      [2:0]   affect
);

    logic [8:0] sum9;
    logic [4:0] nib5;

    // Subtraction is opa plus the complement of opb plus one, so both carries
    // come out high when no borrow occurs.
    assign sum9 = (op == CSB_OP_SUB) ? ({1'b0, opa} + {1'b0, ~opb} + 9'h001)
                                     : ({1'b0, opa} + {1'b0, opb});
    assign nib5 = (op == CSB_OP_SUB) ? ({1'b0, opa[3:0]} + {1'b0, ~opb[3:0]} + 5'h01)
                                     : ({1'b0, opa[3:0]} + {1'b0, opb[3:0]});

    always_comb
    begin
        result = opa;
        flags  = 3'h0;
        affect = 3'h0;
        case (op)
            CSB_OP_ADD, CSB_OP_SUB:
            begin
                result = sum9[7:0];
                flags  = {(sum9[7:0] == 8'h00), nib5[4], sum9[8]};
                affect = 3'h7;
            end
            CSB_OP_LOGIC:
            begin
                flags  = {(opa == 8'h00), 2'h0};
                affect = 3'h4;
            end
            CSB_OP_ROTL:
            begin
                result = {opa[6:0], carry_in};
                flags  = {2'h0, opa[7]};
                affect = 3'h1;
            end
            CSB_OP_ROTR:
            begin
                result = {carry_in, opa[7:1]};
                flags  = {2'h0, opa[0]};
                affect = 3'h1;
            end
            default:
            begin
                result = opa;
            end
        endcase
    end

endmodule // csb_flag_unit

//--- src/csb_addr_former.sv
`timescale 1ns/10ps
module csb_addr_former
    import csb_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [1:0]           direct_bank_field,
    input  wire logic                 indirect_bank_bit,
    input  wire logic [CSB_OFS_W-1:0] dir_offset,
    input  wire logic [7:0]           fsr_value,
    output logic      [8:0]           dir_addr_q,
    output logic      [8:0]           ind_addr_q
);

    logic [8:0] dir_addr_d;
    logic [8:0] ind_addr_d;

    // Bank bits sit straight above the in-bank offset.
    assign dir_addr_d = {direct_bank_field, dir_offset};
    assign ind_addr_d = {indirect_bank_bit, fsr_value};

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dir_addr_q <= 9'h000;
            ind_addr_q <= 9'h000;
        end
        else
        begin
            dir_addr_q <= dir_addr_d;
            ind_addr_q <= ind_addr_d;
        end
    end

endmodule // csb_addr_former

//--- src/csb_status_top.sv
// Chosen here: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
module csb_status_top
    import csb_pkg::*;
(
    input  wire logic                 core_clk,
    input  wire logic                 rst_n,
    input  wire logic [1:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    input  wire logic                 core_wr_en,
    input  wire logic [7:0]           core_wr_data,
    input  wire logic                 alu_valid,
    input  csb_alu_op_t               alu_op,
    input  wire logic [7:0]           alu_opa,
    input  wire logic [7:0]           alu_opb,
    input  wire logic                 watchdog_kick_op,
    input  wire logic                 sleep_op,
    input  wire logic                 watchdog_timer_expired,
    input  wire logic [CSB_OFS_W-1:0] dir_offset,
    input  wire logic [7:0]           fsr_value,
    output logic      [7:0]           core_status_q,
    output logic      [7:0]           alu_result_q,
    output logic      [8:0]           dir_addr_q,
    output logic      [8:0]           ind_addr_q
);

    logic [7:0]  status_d;
    logic [7:0]  result_d;
    logic [2:0]  shadow_flags_q;
    logic [2:0]  shadow_flags_d;
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    wire         bus_req;
    wire         bus_start;
    wire         bus_done_wr;
    wire         bus_wr_status;
    wire         sw_wr;
    wire  [7:0]  sw_data;
    wire  [7:0]  alu_res_w;
    wire  [2:0]  alu_flags_w;
    wire  [2:0]  alu_affect_w;
    wire         flag_op;
    wire  [7:0]  sw_mask;
    wire  [7:0]  alu_mask;
    wire  [7:0]  after_sw;
    wire  [7:0]  after_alu;
    wire         expiry_n_d;
    wire         sleep_n_d;
    wire  [31:0] rd_mux;

    function automatic logic [31:0] csb_read_word(
        input logic [1:0]  adr,
        input logic [7:0]  st,
        input logic [7:0]  res,
        input logic [2:0]  flg,
        input logic [8:0]  dira,
        input logic [8:0]  inda
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        case (adr)
            CSB_ADR_STATUS: w = {24'h00_0000, st};
            CSB_ADR_SHADOW: w = {21'h00_0000, flg, res};
            CSB_ADR_ADDR:   w = {7'h00, inda, 7'h00, dira};
            default:        w = 32'h0000_0000;
        endcase
        return w;
    endfunction

    // Bus slave: every access waits one cycle, then completes in the next.
    assign bus_req       = avs_read | avs_write;
    assign bus_start     = bus_req & wait_q;
    assign bus_done_wr   = avs_write & ~wait_q;
    assign bus_wr_status = bus_done_wr & avs_byteenable[0]
                         & (avs_address == CSB_ADR_STATUS);

    assign wait_d  = ~bus_start;
    assign rd_mux  = csb_read_word(avs_address, core_status_q, alu_result_q,
                                   shadow_flags_q, dir_addr_q, ind_addr_q);
    assign rdata_d = (avs_read & wait_q) ? rd_mux : rdata_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    csb_flag_unit u_flag_unit (
        .op       (alu_valid ? alu_op : CSB_OP_NONE),
        .opa      (alu_opa),
        .opb      (alu_opb),
        .carry_in (core_status_q[CSB_BIT_CRY]),
        .result   (alu_res_w),
        .flags    (alu_flags_w),
        .affect   (alu_affect_w)
    );

    // The core port wins over the bus when both write in one cycle, since an
    // instruction cannot be stalled while a bus access can be retried.
    assign sw_wr   = core_wr_en | bus_wr_status;
    assign sw_data = core_wr_en ? core_wr_data : avs_writedata[7:0];
    assign flag_op = alu_valid & (|alu_affect_w);

    assign sw_mask = ~sw_wr   ? 8'h00
                   : flag_op  ? (CSB_WR_MASK & ~CSB_ALU_MASK)
                   :            CSB_WR_MASK;

    assign alu_mask = flag_op ? {5'h00, alu_affect_w} : 8'h00;

    assign after_sw  = (core_status_q & ~sw_mask) | (sw_data & sw_mask);
    assign after_alu = (after_sw & ~alu_mask) | ({5'h00, alu_flags_w} & alu_mask);

    // Expiry is the rarer and more telling event, so it outranks a kick
    // or a sleep that lands on the same edge.
    assign expiry_n_d = watchdog_timer_expired ? 1'b0
                      : (watchdog_kick_op | sleep_op) ? 1'b1
                      : core_status_q[CSB_BIT_WEXP];

    assign sleep_n_d = sleep_op ? 1'b0
                     : watchdog_kick_op ? 1'b1
                     : core_status_q[CSB_BIT_SLP];

    always_comb
    begin
        status_d                = after_alu;
        status_d[CSB_BIT_WEXP]  = expiry_n_d;
        status_d[CSB_BIT_SLP]   = sleep_n_d;
    end

    assign result_d       = flag_op ? alu_res_w : alu_result_q;
    assign shadow_flags_d = flag_op ? alu_flags_w : shadow_flags_q;

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_status_q  <= CSB_STATUS_RST;
            alu_result_q   <= 8'h00;
            shadow_flags_q <= 3'h0;
        end
        else
        begin
            core_status_q  <= status_d;
            alu_result_q   <= result_d;
            shadow_flags_q <= shadow_flags_d;
        end
    end

    // The reserved bank bits are stored as written; firmware keeps them clear.
    csb_addr_former u_addr_former (
        .core_clk          (core_clk),
        .rst_n             (rst_n),
        .direct_bank_field (core_status_q[CSB_BIT_HI:CSB_BIT_LO]),
        .indirect_bank_bit (core_status_q[CSB_BIT_IND]),
        .dir_offset        (dir_offset),
        .fsr_value         (fsr_value),
        .dir_addr_q        (dir_addr_q),
        .ind_addr_q        (ind_addr_q)
    );

endmodule // csb_status_top

//--- test/csb_status_checker.sv
`timescale 1ns/10ps
module csb_status_checker
    import csb_pkg::*;
(
    input wire logic                 core_clk,
    input wire logic                 rst_n,
    input wire logic                 alu_valid,
    input csb_alu_op_t               alu_op,
    input wire logic [7:0]           alu_opa,
    input wire logic [7:0]           alu_opb,
    input wire logic                 watchdog_kick_op,
    input wire logic                 sleep_op,
    input wire logic                 watchdog_timer_expired,
    input wire logic [CSB_OFS_W-1:0] dir_offset,
    input wire logic [7:0]           fsr_value,
    input wire logic [7:0]           core_status_q,
    input wire logic [8:0]           dir_addr_q,
    input wire logic [8:0]           ind_addr_q
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    wire [8:0] s9 = {1'b0, alu_opa} + {1'b0, alu_opb};
    wire [4:0] n5 = {1'b0, alu_opa[3:0]} + {1'b0, alu_opb[3:0]};
    wire [2:0] add_f = {s9[7:0] == 8'h00, n5[4], s9[8]};
    // Subtract flags read one when no borrow is needed.
    wire [1:0] sub_f = {alu_opa[3:0] >= alu_opb[3:0], alu_opa >= alu_opb};
    AST_EXP_CLR: assert property (watchdog_timer_expired |=> !core_status_q[4])
        else $error("time-out flag kept after expiry");
    AST_KICK: assert property (watchdog_kick_op && !sleep_op
        && !watchdog_timer_expired |=> core_status_q[4:3] == 2'b11)
        else $error("kick did not set both flags");
    AST_SLEEP: assert property (sleep_op && !watchdog_timer_expired
        |=> core_status_q[4:3] == 2'b10) else $error("sleep flags wrong");
    AST_HOLD: assert property (!(watchdog_kick_op || sleep_op || watchdog_timer_expired)
        |=> $stable(core_status_q[4:3])) else $error("cause flags moved without event");
    AST_ADD: assert property (alu_valid && alu_op == CSB_OP_ADD
        |=> core_status_q[2:0] == $past(add_f)) else $error("add flags wrong");
    AST_SUB: assert property (alu_valid && alu_op == CSB_OP_SUB
        |=> core_status_q[1:0] == $past(sub_f)) else $error("subtract borrow flags wrong");
    AST_DIR: assert property (1'b1 |=>
        dir_addr_q == {$past(core_status_q[6:5]), $past(dir_offset)})
        else $error("direct address wrong");
    AST_IND: assert property (1'b1 |=> ind_addr_q == {$past(core_status_q[7]),
        $past(fsr_value)}) else $error("indirect address wrong");
endmodule // csb_status_checker

bind csb_status_top csb_status_checker chk (
    .core_clk(core_clk), .rst_n(rst_n), .alu_valid(alu_valid), .alu_op(alu_op),
    .alu_opa(alu_opa), .alu_opb(alu_opb), .watchdog_kick_op(watchdog_kick_op),
    .sleep_op(sleep_op), .watchdog_timer_expired(watchdog_timer_expired),
    .dir_offset(dir_offset), .fsr_value(fsr_value), .core_status_q(core_status_q),
    .dir_addr_q(dir_addr_q), .ind_addr_q(ind_addr_q)
);

//--- test/tb_csb_status_top.sv
`timescale 1ns/10ps
module tb_csb_status_top
    import csb_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [1:0]  adr = 2'h0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic        wait_r;
    logic [4:0]  ctl = 5'h0;
    logic [7:0]  wd = 8'h0;
    logic [7:0]  opa = 8'h0;
    logic [7:0]  opb = 8'h0;
    logic [7:0]  fsr = 8'h0;
    logic [6:0]  ofs = 7'h0;
    csb_alu_op_t op = CSB_OP_NONE;
    logic [7:0]  st, res, a, b, d;
    logic [8:0]  dira, inda;
    logic [10:0] ex;
    logic [31:0] rd;
    logic [7:0]  m;
    csb_alu_op_t oj;
    int          seed = 32'hd223;
    int          mismatches = 0;
    int          tests_run = 0;

    always #12.5 clk = ~clk;

    csb_status_top uut (
        .core_clk(clk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd_en),
        .avs_write(wr_en), .avs_writedata(wdat), .avs_byteenable(4'h1),
        .avs_readdata(rdat), .avs_waitrequest(wait_r), .core_wr_en(ctl[3]),
        .core_wr_data(wd), .alu_valid(ctl[4]), .alu_op(op), .alu_opa(opa), .alu_opb(opb),
        .watchdog_kick_op(ctl[2]), .sleep_op(ctl[1]), .watchdog_timer_expired(ctl[0]),
        .dir_offset(ofs), .fsr_value(fsr), .core_status_q(st), .alu_result_q(res),
        .dir_addr_q(dira), .ind_addr_q(inda)
    );

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        tests_run++;
        if (s !== e)
        begin
            $display("wrong value %s expected %h seen %h", what, e, s);
            mismatches++;
        end
    endtask

    function automatic logic [10:0] alu_exp(csb_alu_op_t o, logic [7:0] x, logic [7:0] y);
        logic [7:0] yy;
        logic [8:0] s;
        logic [4:0] h;
        yy = (o == CSB_OP_SUB) ? ~y : y;
        s = {1'b0, x} + {1'b0, yy} + 9'(o == CSB_OP_SUB);
        h = {1'b0, x[3:0]} + {1'b0, yy[3:0]} + 5'(o == CSB_OP_SUB);
        return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
    endfunction

    // Logic ops touch only the zero flag; rotates go through the carry and keep the rest.
    function automatic logic [10:0] misc_exp(csb_alu_op_t o, logic [7:0] x, logic [2:0] f);
        logic [10:0] r;
        case (o)
            CSB_OP_LOGIC: r = {x == 8'h00, f[1:0], x};
            CSB_OP_ROTL:  r = {f[2:1], x[7], x[6:0], f[0]};
            default:      r = {f[2:1], x[0], f[0], x[7:1]};
        endcase
        return r;
    endfunction

    task automatic step(input logic [4:0] c, input logic [7:0] dv, x, y, input csb_alu_op_t o);
        @(posedge clk);
        ctl <= c;
        wd <= dv;
        opa <= x;
        opb <= y;
        op <= o;
        ofs <= 7'($random(seed));
        fsr <= 8'($random(seed));
        @(posedge clk);
        ctl <= 5'h0;
        #1;
    endtask

    // The request is held until an edge samples waitrequest low.
    task automatic bus(input logic w, input logic [1:0] ad, input logic [7:0] dv);
        int n;
        n = 0;
        @(posedge clk);
        adr <= ad;
        wr_en <= w;
        rd_en <= !w;
        wdat <= {24'h0, dv};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wait_r !== 1'b0 && n < 16);
        rd = rdat;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        if (wait_r !== 1'b0)
        begin
            mismatches++;
            give_verdict();
        end
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        check("status in reset", {24'h0, CSB_STATUS_RST}, {24'h0, st});
        rst_n <= 1'b1;
        m = CSB_STATUS_RST;
        bus(1'b0, CSB_ADR_STATUS, 8'h0);
        check("status read", {24'h0, m}, rd);
        for (int i = 0; i < 40; i++)
        begin
            a = (i == 0) ? 8'h0f : (i == 2) ? 8'hff : 8'($random(seed));
            b = (i == 0 || i == 2) ? 8'h01 : (i == 1) ? a : 8'($random(seed));
            d = 8'($random(seed)) & 8'h7f;
            ex = alu_exp(i[0] ? CSB_OP_SUB : CSB_OP_ADD, a, b);
            step({1'b1, i[1], 3'h0}, d, a, b, i[0] ? CSB_OP_SUB : CSB_OP_ADD);
            if (i[1]) m[7:5] = d[7:5];
            m[2:0] = ex[10:8];
            check("alu flags", {29'h0, ex[10:8]}, {29'h0, st[2:0]});
            check("written bank bits", {29'h0, m[7:5]}, {29'h0, st[7:5]});
            check("alu result", {24'h0, ex[7:0]}, {24'h0, res});
        end
        for (int j = 0; j < 12; j++)
        begin
            oj = (j % 3 == 0) ? CSB_OP_LOGIC : (j % 3 == 1) ? CSB_OP_ROTL : CSB_OP_ROTR;
            a = (j < 3) ? 8'h00 : 8'($random(seed));
            d = 8'($random(seed)) & 8'h7f;
            ex = misc_exp(oj, a, m[2:0]);
            step({1'b1, j[0], 3'h0}, d, a, 8'h00, oj);
            if (j[0]) m[7:5] = d[7:5];
            m[2:0] = ex[10:8];
            check("logic and rotate status", {24'h0, m}, {24'h0, st});
            check("logic and rotate result", {24'h0, ex[7:0]}, {24'h0, res});
        end
        for (int e = 1; e < 8; e++)
        begin
            step({2'b0, e[2:0]}, 8'h0, 8'h0, 8'h0, CSB_OP_NONE);
            if (e[1] | e[2]) m[4] = 1'b1;
            if (e[0]) m[4] = 1'b0;
            if (e[2]) m[3] = 1'b1;
            if (e[1]) m[3] = 1'b0;
            check("cause flags", {30'h0, m[4:3]}, {30'h0, st[4:3]});
        end
        for (int k = 0; k < 4; k++)
        begin
            d = {2'b00, k[0], ~m[4:3], 3'($random(seed))};
            bus(1'b1, CSB_ADR_STATUS, d);
            m = {d[7:5], m[4:3], d[2:0]};
            step(5'h0, 8'h0, 8'h0, 8'h0, CSB_OP_NONE);
            check("direct address", {23'h0, d[6:5], ofs}, {23'h0, dira});
            check("indirect address", {23'h0, d[7], fsr}, {23'h0, inda});
            bus(1'b0, CSB_ADR_STATUS, 8'h0);
            check("status after write", {24'h0, m}, rd);
        end
        d = ~m & 8'h7f;
        step(5'h08, d, 8'h0, 8'h0, CSB_OP_NONE);
        m = {d[7:5], m[4:3], d[2:0]};
        check("core write", {24'h0, m}, {24'h0, st});
        bus(1'b1, 2'h3, 8'hff);
        bus(1'b0, 2'h3, 8'h0);
        check("unmapped read", 32'h0, rd);
        bus(1'b0, CSB_ADR_ADDR, 8'h0);
        check("address word", {7'h0, m[7], fsr, 7'h0, m[6:5], ofs}, rd);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        #1;
        check("status after reset", {24'h0, CSB_STATUS_RST}, {24'h0, st});
        give_verdict();
    end
endmodule // tb_csb_status_top
